// file: omm_pkg.sv
package omm_pkg;

  // ****************************************************************
  // Segment attributes and address layout
  // ****************************************************************
  typedef enum logic [1:0] {
    OMM_ATTR_PASS = 2'h0,
    OMM_ATTR_RW   = 2'h1,
    OMM_ATTR_RO   = 2'h2,
    OMM_ATTR_FORB = 2'h3
  } omm_attr_t;

  localparam int SEG_BYTES      = 2048;
  localparam int SEG_SHIFT      = 11;
  localparam int OVL_MIN_BYTES  = 32768;
  localparam int OVL_MAX_BYTES  = 524288;
  localparam int OVL_DEF_BYTES  = 131072;

  // ****************************************************************
  // APB register offsets
  // ****************************************************************
  localparam logic [11:0] REG_CTRL     = 12'h0_000;
  localparam logic [11:0] REG_MAP_LO   = 12'h0_004;
  localparam logic [11:0] REG_MAP_HI   = 12'h0_008;
  localparam logic [11:0] REG_MAP_CMD  = 12'h0_00C;
  localparam logic [11:0] REG_STATUS   = 12'h0_010;
  localparam logic [11:0] REG_SHOW_IDX = 12'h0_014;
  localparam logic [11:0] REG_SHOW_DAT = 12'h0_018;
  localparam logic [11:0] REG_SEG_CNT  = 12'h0_01C;

  // CTRL fields
  localparam int CTRL_QUAL_LSB  = 0;
  localparam int CTRL_WAIT_LSB  = 8;
  localparam int CTRL_PAUSE_BIT = 12;
  // CMD codes
  localparam logic [1:0] CMD_MAP   = 2'h1;
  localparam logic [1:0] CMD_CLEAR = 2'h2;
  localparam int CMD_ATTR_LSB  = 4;
  localparam int CMD_NAMED_BIT = 6;

  // Power-up settings (qualifier: user data, user program, supervisor data/program) and all-spaces qualifier values
  localparam logic [7:0] QUAL_RESET     = 8'h6_6;
  localparam logic [7:0] QUAL_ALL_16BIT = 8'hE_6;
  localparam logic [7:0] QUAL_ALL_LATER = 8'hF_F;
  localparam logic [2:0] WAIT_RESET_24  = 3'h0;
  localparam logic [2:0] WAIT_RESET_32  = 3'h1;

  // Target bus cycle bundle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  space;
    logic [31:0] addr;
  } omm_cycle_t;

  // Cycle decision bundle
  typedef struct packed {
    logic        to_overlay;
    logic        write_viol;
    logic        access_viol;
    logic [31:0] ovl_addr;
  } omm_decision_t;

endpackage : omm_pkg

// file: omm_seg_table.sv
`timescale 1ns/1ps
// Per-segment attribute and slot memory, registered read ports
module omm_seg_table #(
  parameter int SEGS   = 8192,
  parameter int SLOT_W = 8
) (
  input  wire logic                     core_clk,
  input  wire logic [$clog2(SEGS)-1:0]  rd_idx,
  output logic      [1+SLOT_W:0]        rd_data,
  input  wire logic [$clog2(SEGS)-1:0]  sw_idx,
  output logic      [1+SLOT_W:0]        sw_data,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(SEGS)-1:0]  wr_idx,
  input  wire logic [1+SLOT_W:0]        wr_data
);

  logic [1+SLOT_W:0] mem [SEGS];

  // ****************************************************************
  // Storage
  // ****************************************************************
  // No reset on the array; the mapper sweeps it to passthrough
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
    sw_data <= mem[sw_idx];
  end

endmodule : omm_seg_table

// file: omm_wait_gen.sv
`timescale 1ns/1ps
// Counts memory wait setting cycles before overlay ready
module omm_wait_gen (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic [2:0] waits,
  output logic            done
);

  logic [2:0] cnt_reg;
  logic       busy_reg;

  // Zero waits completes in the start cycle itself
  assign done = (start && waits == 3'h0) || (busy_reg && cnt_reg == 3'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_reg  <= 3'h0;
      busy_reg <= 1'b0;
    end else if (start && waits != 3'h0) begin
      cnt_reg  <= waits;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg  <= cnt_reg - 3'h1;
      busy_reg <= cnt_reg != 3'h1;
    end
  end

endmodule : omm_wait_gen

// file: omm_mapper.sv
`timescale 1ns/1ps
module omm_mapper #(
  parameter int ADDR_W    = 24,
  parameter int OVL_BYTES = omm_pkg::OVL_DEF_BYTES,
  parameter bit LATER_CPU = 1'b0
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire omm_pkg::omm_cycle_t         cyc,
  output omm_pkg::omm_decision_t           dec,
  output logic                             dec_valid,
  output logic                             ovl_ready,
  output logic                             run_abort
);

  localparam int SEGS   = 1 << (ADDR_W - omm_pkg::SEG_SHIFT);
  localparam int IDX_W  = ADDR_W - omm_pkg::SEG_SHIFT;
  localparam int NSLOT  = OVL_BYTES / omm_pkg::SEG_BYTES;
  localparam int SLOT_W = $clog2(NSLOT);

  // Elaboration checks
  if (OVL_BYTES < omm_pkg::OVL_MIN_BYTES || OVL_BYTES > omm_pkg::OVL_MAX_BYTES ||
      (OVL_BYTES % omm_pkg::SEG_BYTES) != 0) begin : g_bad_size
    $error("overlay size out of range");
  end
  if (ADDR_W != 24 && ADDR_W != 32) begin : g_bad_aw
    $error("address width must be 24 or 32");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  // 2K segment index
  function automatic logic [IDX_W-1:0] seg_of(input logic [31:0] a);
    seg_of = a[ADDR_W-1:omm_pkg::SEG_SHIFT];
  endfunction : seg_of

  function automatic logic uses_ovl(input logic [1:0] at);
    uses_ovl = at == omm_pkg::OMM_ATTR_RW || at == omm_pkg::OMM_ATTR_RO;
  endfunction : uses_ovl

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic [7:0]       qual_reg;
  logic [2:0]       wait_reg;
  logic             pause_reg;
  logic [31:0]      lo_reg;
  logic [31:0]      hi_reg;
  logic [IDX_W-1:0] show_idx_reg;
  logic             wviol_reg;
  logic             aviol_reg;
  logic             full_reg;
  logic [SLOT_W:0]  used_reg;

  typedef enum logic [3:0] {
    OMM_ST_SWEEP = 4'b0001,
    OMM_ST_IDLE  = 4'b0010,
    OMM_ST_READ  = 4'b0100,
    OMM_ST_WRITE = 4'b1000
  } omm_state_t;
  omm_state_t      state_reg;
  logic [IDX_W-1:0] cur_reg;
  logic [IDX_W-1:0] end_reg;
  logic [1:0]       attr_reg;

  wire apb_wr   = psel && penable && pwrite;
  wire apb_rd   = psel && penable && !pwrite;
  wire busy     = state_reg != OMM_ST_IDLE;
  wire cmd_hit  = apb_wr && paddr == omm_pkg::REG_MAP_CMD;
  wire [1:0] cmd_op = pwdata[1:0];

  wire [1:0] cmd_attr = pwdata[omm_pkg::CMD_NAMED_BIT] ?
                        pwdata[omm_pkg::CMD_ATTR_LSB +: 2] : omm_pkg::OMM_ATTR_RW;
  // single address when upper bound below lower
  wire [31:0] range_hi = (hi_reg < lo_reg) ? lo_reg : hi_reg;
  wire [7:0] all_spaces = LATER_CPU ? omm_pkg::QUAL_ALL_LATER : omm_pkg::QUAL_ALL_16BIT;
  wire [7:0] qual_wr    = (pwdata[7:0] == 8'hF_F) ? all_spaces : pwdata[7:0];

  // ****************************************************************
  // Segment table
  // ****************************************************************
  logic [1+SLOT_W:0] lk_data;
  logic [1+SLOT_W:0] sw_data;
  logic              tbl_we;
  logic [1+SLOT_W:0] tbl_wd;

  omm_seg_table #(.SEGS(SEGS), .SLOT_W(SLOT_W)) u_tbl (
    .core_clk (core_clk),
    .rd_idx   (seg_of(cyc.addr)),
    .rd_data  (lk_data),
    .sw_idx   (state_reg == OMM_ST_IDLE ? show_idx_reg : cur_reg),
    .sw_data  (sw_data),
    .wr_en    (tbl_we),
    .wr_idx   (cur_reg),
    .wr_data  (tbl_wd)
  );

  // Map update writes: keep a slot once held, take a new one only if needed
  wire [1:0]        old_attr = sw_data[1+SLOT_W:SLOT_W];
  wire              need_new = uses_ovl(attr_reg) && !uses_ovl(old_attr);
  wire              no_room  = need_new && used_reg >= (SLOT_W+1)'(NSLOT);
  wire [SLOT_W-1:0] slot_sel = need_new ? used_reg[SLOT_W-1:0] : sw_data[SLOT_W-1:0];
  assign tbl_we = state_reg == OMM_ST_SWEEP ||
                  (state_reg == OMM_ST_WRITE && !no_room);
  assign tbl_wd = state_reg == OMM_ST_SWEEP ? {omm_pkg::OMM_ATTR_PASS, {SLOT_W{1'b0}}} :
                  {attr_reg, slot_sel};

  // ****************************************************************
  // Map update sequencer
  // ****************************************************************
  // whole enclosing segments
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg <= OMM_ST_SWEEP;
      cur_reg   <= '0;
      end_reg   <= '1;
      attr_reg  <= omm_pkg::OMM_ATTR_PASS;
      used_reg  <= '0;
      full_reg  <= 1'b0;
    end else begin
      case (state_reg)
        OMM_ST_SWEEP: begin
          cur_reg <= cur_reg + 1'b1;
          if (cur_reg == end_reg) begin
            state_reg <= OMM_ST_IDLE;
            used_reg  <= '0;
          end
        end
        OMM_ST_IDLE: begin
          if (cmd_hit && pause_reg && cmd_op == omm_pkg::CMD_CLEAR) begin
            state_reg <= OMM_ST_SWEEP;
            cur_reg   <= '0;
            end_reg   <= '1;
            full_reg  <= 1'b0;
          end else if (cmd_hit && pause_reg && cmd_op == omm_pkg::CMD_MAP) begin
            state_reg <= OMM_ST_READ;
            cur_reg   <= seg_of(lo_reg);
            end_reg   <= seg_of(range_hi);
            attr_reg  <= cmd_attr;
            full_reg  <= 1'b0;
          end
        end
        OMM_ST_READ: state_reg <= OMM_ST_WRITE;
        OMM_ST_WRITE: begin
          if (no_room) begin
            full_reg  <= 1'b1;
            state_reg <= OMM_ST_IDLE;
          end else begin
            if (need_new) begin
              used_reg <= used_reg + 1'b1;
            end
            cur_reg   <= cur_reg + 1'b1;
            state_reg <= cur_reg == end_reg ? OMM_ST_IDLE : OMM_ST_READ;
          end
        end
        default: state_reg <= OMM_ST_SWEEP;
      endcase
    end
  end

  // ****************************************************************
  // Target cycle decision, one cycle after the lookup
  // ****************************************************************
  omm_pkg::omm_cycle_t cyc_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cyc_reg <= '0;
    end else begin
      cyc_reg <= cyc;
    end
  end

  wire [1:0] lk_attr = lk_data[1+SLOT_W:SLOT_W];
  wire space_on  = qual_reg[cyc_reg.space];
  // Lookups are not trusted while the map is being rewritten
  wire live      = cyc_reg.valid && !busy && !pause_reg;
  // target writes to read-only never reach overlay
  wire hit_ovl   = live && uses_ovl(lk_attr) && space_on &&
                   !(cyc_reg.write && lk_attr == omm_pkg::OMM_ATTR_RO);
  wire hit_wviol = live && cyc_reg.write && lk_attr == omm_pkg::OMM_ATTR_RO;
  wire hit_aviol = live && lk_attr == omm_pkg::OMM_ATTR_FORB;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dec       <= '0;
      dec_valid <= 1'b0;
    end else begin
      dec.to_overlay  <= hit_ovl;
      dec.write_viol  <= hit_wviol;
      dec.access_viol <= hit_aviol;
      dec.ovl_addr    <= 32'({lk_data[SLOT_W-1:0], cyc_reg.addr[omm_pkg::SEG_SHIFT-1:0]});
      dec_valid       <= live;
    end
  end

  // zero-wait completion unless a wait setting asks otherwise
  omm_wait_gen u_wait (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (hit_ovl),
    .waits    (wait_reg),
    .done     (ovl_ready)
  );

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  // Violations latch and stop run; set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      qual_reg     <= omm_pkg::QUAL_RESET;
      wait_reg     <= ADDR_W == 32 ? omm_pkg::WAIT_RESET_32 : omm_pkg::WAIT_RESET_24;
      pause_reg    <= 1'b1;
      lo_reg       <= '0;
      hi_reg       <= '0;
      show_idx_reg <= '0;
      wviol_reg    <= 1'b0;
      aviol_reg    <= 1'b0;
    end else begin
      if (apb_wr && paddr == omm_pkg::REG_CTRL) begin
        qual_reg  <= qual_wr;
        wait_reg  <= pwdata[omm_pkg::CTRL_WAIT_LSB +: 3];
        pause_reg <= pwdata[omm_pkg::CTRL_PAUSE_BIT];
      end
      if (hit_wviol || hit_aviol) begin
        pause_reg <= 1'b1;
      end
      if (apb_wr && paddr == omm_pkg::REG_MAP_LO) lo_reg <= pwdata;
      if (apb_wr && paddr == omm_pkg::REG_MAP_HI) hi_reg <= pwdata;
      if (apb_wr && paddr == omm_pkg::REG_SHOW_IDX) show_idx_reg <= pwdata[IDX_W-1:0];
      wviol_reg <= hit_wviol || (wviol_reg &&
                   !(apb_wr && paddr == omm_pkg::REG_STATUS && pwdata[0]));
      aviol_reg <= hit_aviol || (aviol_reg &&
                   !(apb_wr && paddr == omm_pkg::REG_STATUS && pwdata[1]));
    end
  end

  assign run_abort = wviol_reg || aviol_reg;

  // ****************************************************************
  // APB read path
  // ****************************************************************
  // Show data needs a table read, so that register waits one cycle
  logic show_wait_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      show_wait_reg <= 1'b0;
    end else begin
      show_wait_reg <= apb_rd && paddr == omm_pkg::REG_SHOW_DAT && !show_wait_reg;
    end
  end

  wire is_show  = paddr == omm_pkg::REG_SHOW_DAT;
  wire show_bad = is_show && (!pause_reg || busy);
  wire mapped   = paddr[11:5] == 7'h0_0 && paddr[1:0] == 2'h0;
  assign pready  = !(apb_rd && is_show && !show_bad && !show_wait_reg);
  assign pslverr = psel && penable && (!mapped || show_bad);

  wire [31:0] rd_mux =
    paddr == omm_pkg::REG_CTRL     ? 32'({pause_reg, 1'b0, wait_reg, qual_reg}) :
    paddr == omm_pkg::REG_MAP_LO   ? lo_reg :
    paddr == omm_pkg::REG_MAP_HI   ? hi_reg :
    paddr == omm_pkg::REG_STATUS   ? 32'({full_reg, busy, aviol_reg, wviol_reg}) :
    paddr == omm_pkg::REG_SHOW_IDX ? 32'(show_idx_reg) :
    paddr == omm_pkg::REG_SHOW_DAT ? 32'(sw_data[1+SLOT_W:SLOT_W]) :
    paddr == omm_pkg::REG_SEG_CNT  ? 32'(used_reg) : 32'h0000_0000;

  // Capture in setup and wait cycles, so data stands at the taking edge
  wire rd_load = psel && !pwrite && !(penable && pready);
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (rd_load) begin
      prdata <= show_bad ? 32'h0000_0000 : rd_mux;
    end
  end

endmodule : omm_mapper

// file: omm_mapper_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Decision and bus timing checker
// ****************************************************************
module omm_mapper_sva #(
  parameter int ADDR_W    = 24,
  parameter int OVL_BYTES = omm_pkg::OVL_DEF_BYTES
) (
  input wire logic                   core_clk,
  input wire logic                   rst_b,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire omm_pkg::omm_cycle_t    cyc,
  input wire omm_pkg::omm_decision_t dec,
  input wire logic                   dec_valid,
  input wire logic                   ovl_ready,
  input wire logic                   run_abort
);
  default clocking dck @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Decisions only ever follow a real cycle
  chk_dec_timing: assert property (dec_valid |-> $past(cyc.valid, 2))
    else $error("decision without a cycle two clocks earlier");
  chk_viol_abort: assert property (dec_valid && (dec.write_viol || dec.access_viol)
    |-> ##[0:2] run_abort)
    else $error("violation did not abort run");
  chk_forb_no_ovl: assert property (dec_valid && dec.access_viol |-> !dec.to_overlay)
    else $error("forbidden access sent to overlay");
  chk_wviol_write: assert property (dec_valid && dec.write_viol |-> $past(cyc.write, 2))
    else $error("write violation on a read");
  chk_seg_offset: assert property (dec_valid && dec.to_overlay
    |-> dec.ovl_addr[10:0] == $past(cyc.addr[10:0], 2))
    else $error("offset inside segment lost");
  chk_apb_ready: assert property (psel && penable && paddr != omm_pkg::REG_SHOW_DAT
    |-> pready)
    else $error("unexpected wait state");
  chk_show_wait: assert property (psel && !penable && !pwrite && paddr == omm_pkg::REG_SHOW_DAT
    ##1 psel && penable && !pslverr |-> !pready ##1 pready)
    else $error("map readout wait wrong");
  // Reset has to be seen, so this one is never disabled
  chk_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !dec_valid && !run_abort)
    else $error("outputs active after reset");
  cover property (dec_valid && dec.to_overlay);
  cover property (dec_valid && dec.write_viol);
  cover property (dec_valid && dec.access_viol);
endmodule : omm_mapper_sva

bind omm_mapper omm_mapper_sva #(.ADDR_W(ADDR_W), .OVL_BYTES(OVL_BYTES)) u_sva (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cyc(cyc), .dec(dec), .dec_valid(dec_valid), .ovl_ready(ovl_ready),
  .run_abort(run_abort));

// file: omm_tgt_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Target processor bus cycle source
// ****************************************************************
module omm_tgt_model (
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                go,
  input wire omm_pkg::omm_cycle_t req,
  output omm_pkg::omm_cycle_t     cyc
);
  // Idle bus clears valid and flips the other fields so a stale address never looks valid
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cyc <= '0;
    end else if (go) begin
      cyc <= req;
    end else begin
      cyc <= omm_pkg::omm_cycle_t'({1'b0, ~cyc[35:0]});
    end
  end
endmodule : omm_tgt_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Stimulus, expectations and verdict
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  spaces;
    logic        w;
    logic [2:0]  sp;
    logic [31:0] a;
    logic        ovl;
  } omm_row_t;
  logic                   core_clk = 1'b0;
  logic                   rst_b    = 1'b0;
  logic                   psel     = 1'b0;
  logic                   penable  = 1'b0;
  logic                   pwrite   = 1'b0;
  logic [11:0]            paddr    = 12'h0_000;
  logic [31:0]            pwdata   = 32'h0000_0000;
  logic                   go       = 1'b0;
  omm_pkg::omm_cycle_t    req      = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   dec_valid;
  logic                   ovl_ready;
  logic                   run_abort;
  logic                   ordy;
  logic                   e;
  logic [31:0]            q;
  omm_pkg::omm_cycle_t    cyc;
  omm_pkg::omm_decision_t dec;
  int                     err_count = 0;
  int                     compares  = 0;
  omm_row_t               rows [10];
  logic [31:0]            sidx [4] = '{32'h2, 32'h4, 32'h6, 32'h3};
  logic [31:0]            sexp [4] = '{32'h1, 32'h2, 32'h3, 32'h0};

  always #12.5 core_clk = ~core_clk;

  omm_mapper #(.ADDR_W(24), .OVL_BYTES(32768)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cyc(cyc), .dec(dec), .dec_valid(dec_valid), .ovl_ready(ovl_ready),
    .run_abort(run_abort));
  omm_tgt_model tgt (.core_clk(core_clk), .rst_b(rst_b), .go(go), .req(req), .cyc(cyc));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  // One APB transfer, request held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One read; data is taken at the edge that sees pready
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic settle;
    q = 32'h0000_0004;
    for (int i = 0; i < 3000 && q[2] !== 1'b0; i++) rd(omm_pkg::REG_STATUS);
    chk("map busy", 32'(q[2]), 32'h0000_0000);
  endtask : settle

  task automatic mapc(input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] cmd);
    apb(1'b1, omm_pkg::REG_MAP_LO, lo);
    apb(1'b1, omm_pkg::REG_MAP_HI, hi);
    apb(1'b1, omm_pkg::REG_MAP_CMD, cmd);
    settle;
  endtask : mapc

  // Cycle seen by the block one edge after go; ready then decision follow
  task automatic tcyc(input logic w, input logic [2:0] sp, input logic [31:0] a);
    @(posedge core_clk);
    go  <= 1'b1;
    req <= '{valid: 1'b1, write: w, space: sp, addr: a};
    @(posedge core_clk);
    go  <= 1'b0;
    @(posedge core_clk);
    #1 ordy = ovl_ready;
    @(posedge core_clk);
    #1;
  endtask : tcyc

  task automatic summarize;
    $display("Mismatches %0d of %0d comparisons", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    // Two table sweeps of 8192 cycles plus traffic, with margin
    repeat (40000) @(posedge core_clk);
    err_count++;
    summarize;
  end

  initial begin
    rows = '{'{8'hFF, 1'h0, 3'h6, 32'h0000_1010, 1'h1}, '{8'hFF, 1'h1, 3'h1, 32'h0000_17FF, 1'h1},
             '{8'hFF, 1'h0, 3'h6, 32'h0000_1800, 1'h0}, '{8'hFF, 1'h0, 3'h2, 32'h0000_2000, 1'h1},
             '{8'hFF, 1'h0, 3'h5, 32'h0000_4FFF, 1'h1}, '{8'hFF, 1'h0, 3'h5, 32'h0000_5000, 1'h0},
             '{8'hFF, 1'h0, 3'h0, 32'h0000_4000, 1'h0}, '{8'hFF, 1'h0, 3'h7, 32'h0000_4000, 1'h1},
             '{8'h40, 1'h0, 3'h5, 32'h0000_1010, 1'h0}, '{8'h40, 1'h0, 3'h6, 32'h0000_1010, 1'h1}};
    repeat (20) @(posedge core_clk);
    chk("reset outputs", 32'({pready, dec_valid, run_abort}), 32'h4);
    rst_b <= 1'b1;
    rd(omm_pkg::REG_CTRL);
    chk("ctrl reset", q, 32'h0000_1066);
    rd(12'h0_020);
    chk("unmapped offset", 32'(e), 32'h1);
    settle;
    apb(1'b1, omm_pkg::REG_CTRL, 32'h0000_10FF);
    mapc(32'h0000_1000, 32'h0000_17FF, 32'h0000_0001);
    mapc(32'h0000_2345, 32'h0000_0000, 32'h0000_0061);
    mapc(32'h0000_3000, 32'h0000_3FFF, 32'h0000_0071);
    mapc(32'h0000_4001, 32'h0000_4801, 32'h0000_0051);
    rd(omm_pkg::REG_SEG_CNT);
    chk("slots used", q, 32'h0000_0004);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, omm_pkg::REG_SHOW_IDX, sidx[k]);
      rd(omm_pkg::REG_SHOW_DAT);
      chk("segment attribute", q, sexp[k]);
    end
    // Rows: overlay hit, boundary, pass, enclosing segments, space enables
    foreach (rows[k]) begin
      apb(1'b1, omm_pkg::REG_CTRL, {24'h00_0000, rows[k].spaces});
      tcyc(rows[k].w, rows[k].sp, rows[k].a);
      chk("decision", 32'({dec_valid, dec.to_overlay, dec.write_viol, dec.access_viol, ordy}),
          32'({1'b1, rows[k].ovl, 2'h0, rows[k].ovl}));
    end
    tcyc(1'b0, 3'h6, 32'h0000_4A5C);
    chk("overlay address", dec.ovl_addr, 32'h0000_1A5C);
    rd(omm_pkg::REG_SHOW_DAT);
    chk("readout refused", 32'(e), 32'h1);
    tcyc(1'b1, 3'h5, 32'h0000_2100);
    chk("ro write", 32'({dec_valid, dec.write_viol}), 32'h3);
    rd(omm_pkg::REG_STATUS);
    chk("write viol flag", q & 32'h0000_0003, 32'h0000_0001);
    chk("abort", 32'(run_abort), 32'h1);
    tcyc(1'b0, 3'h6, 32'h0000_1010);
    chk("paused cycle", 32'(dec_valid), 32'h0);
    apb(1'b1, omm_pkg::REG_STATUS, 32'h0000_0003);
    apb(1'b1, omm_pkg::REG_CTRL, 32'h0000_00FF);
    tcyc(1'b0, 3'h5, 32'h0000_3000);
    chk("forbidden read", 32'({dec_valid, dec.to_overlay, dec.access_viol}), 32'h5);
    // Violation left the block paused, so a clear is accepted
    apb(1'b1, omm_pkg::REG_MAP_CMD, 32'h0000_0002);
    settle;
    rd(omm_pkg::REG_SEG_CNT);
    chk("slots after clear", q, 32'h0000_0000);
    apb(1'b1, omm_pkg::REG_SHOW_IDX, 32'h0000_0006);
    rd(omm_pkg::REG_SHOW_DAT);
    chk("cleared attribute", q, 32'h0000_0000);
    // Seventeen segments against sixteen slots
    mapc(32'h0001_0000, 32'h0001_87FF, 32'h0000_0001);
    rd(omm_pkg::REG_STATUS);
    chk("overlay full", q & 32'h0000_0008, 32'h0000_0008);
    rd(omm_pkg::REG_SEG_CNT);
    chk("slots at limit", q, 32'h0000_0010);
    summarize;
  end
endmodule : testbench
